/* event_timer.v */
// Purpose: Sixteen-bit event timer with programmable prescaler and overflow interrupt.
// Assumes: core_clk is the oscillator; four clocks make one instruction cycle.
// Notes: Registers are reached over a plain strobe port with read data one cycle later.
//
// Overview of operation
// - External pin clock is synchronized to the phases after the prescaler.
// - Prescaler output is sampled twice per instruction cycle to find edges.
// - Counter steps five to seven oscillator periods after the pin edge.
// - Sixteen-bit count is reached as two separate eight-bit halves.
// - Writing a half stops that half counting for the next cycle only.
// - Any write to either count half clears the prescaler.
// - Prescale ratio can change at any time without stopping the timer.
// - Control reads zero after reset; count undefined at power-on, else kept.
// - Reset pin and watchdog resets keep the counter contents.
// - Clock source bit five set picks instruction clock, clear the pin.
// - Edge bit six set counts rising pin edges, clear counts falling.
// - Ratio field bits four to one: 1:1 to 1:128, top bit gives 1:256.
// - Counter wraps to zero, sets overflow flag, enable gates, vector clears.
`timescale 1ns/1ps
`default_nettype none
`include "event_timer_regs.vh"
module event_timer
(
   input wire core_clk,
   input wire rst,
   input wire external_reset_pin_n,
   input wire watchdog_timeout,
   input wire counter_clock_pin,
   input wire irq_vector_ack,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [7:0] reg_rdata,
   output reg overflow_irq
);
   // Pin synchronisers; only the second stage is read by logic.
   reg pin_meta_reg;
   reg pin_sync_reg;
   reg pin_prev_reg; // Previous raw synchronised pin level.
   reg xrst_meta_reg;
   reg xrst_sync_reg;
   // Instruction phase counter.
   reg [1:0] phase_reg;
   // Software visible state.
   reg [7:0] control_reg;
   reg irq_disable_reg;
   reg overflow_flag_reg;
   reg overflow_enable_reg;
   reg [7:0] count_low_reg;
   reg [7:0] count_high_reg;
   reg [2:0] hold_low_reg;
   reg [2:0] hold_high_reg;
   // Prescaler output level, toggled on each prescaler tick.
   reg prescaler_output_reg;
   wire soft_reset;
   wire any_reset;
   wire clock_source_select;
   wire pin_edge_select;
   wire [3:0] prescale_ratio_field;
   wire instr_pulse;
   wire sample_now;
   wire pin_event;
   wire source_event;
   wire prescaler_tick;
   wire count_step;
   wire wr_low;
   wire wr_high;
   wire wr_irq;
   wire low_runs;
   wire high_runs;
   wire low_carry;
   wire overflow_event;
   wire overflow_clear;

   // External reset and counter pin come from outside the clock domain.
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
         xrst_meta_reg <= 1'b1;
         xrst_sync_reg <= 1'b1;
      end
      else
      begin
         pin_meta_reg <= counter_clock_pin;
         pin_sync_reg <= pin_meta_reg;
         xrst_meta_reg <= external_reset_pin_n;
         xrst_sync_reg <= xrst_meta_reg;
      end
   end

   // Reset pin and watchdog act as non power-up resets that spare the count.
   assign soft_reset = !xrst_sync_reg || watchdog_timeout;
   assign any_reset = rst || soft_reset;

   // Control fields.
   assign clock_source_select = control_reg[`CTL_CLOCK_SOURCE_BIT];
   assign pin_edge_select = control_reg[`CTL_PIN_EDGE_SELECT_BIT];
   assign prescale_ratio_field = control_reg[`CTL_RATIO_MSB:`CTL_RATIO_LSB];

   // Four phases per instruction cycle; the internal clock fires once per cycle.
   always @(posedge core_clk)
   begin
      if (any_reset)
         phase_reg <= 2'h0;
      else
         phase_reg <= phase_reg + 2'h1;
   end

   assign instr_pulse = (phase_reg == `PHASE_LAST);
   // Two sample points per instruction cycle for the prescaler output.
   assign sample_now = (phase_reg == `SAMPLE_PHASE_A) || (phase_reg == `SAMPLE_PHASE_B);

   // The raw level is remembered, so a reset or a new edge choice makes no false edge.
   always @(posedge core_clk)
   begin
      if (any_reset)
         pin_prev_reg <= 1'b0;
      else
         pin_prev_reg <= pin_sync_reg;
   end

   assign pin_event = pin_edge_select ? (pin_sync_reg && !pin_prev_reg) :
      (!pin_sync_reg && pin_prev_reg);
   // The prescaler sees raw pin events; the phase sampling comes after it.
   assign source_event = clock_source_select ? instr_pulse : pin_event;

   // Register writes decoded per half.
   assign wr_low = reg_write && (reg_addr == `OFS_COUNT_LOW);
   assign wr_high = reg_write && (reg_addr == `OFS_COUNT_HIGH);
   assign wr_irq = reg_write && (reg_addr == `OFS_IRQ_STATUS_ENABLE);

   // The ratio field is read live, so it may change while counting.
   ratio_prescaler u_prescaler
   (
      .core_clk(core_clk),
      .rst(any_reset),
      .source_event(source_event),
      .clear_count(wr_low || wr_high),
      .ratio_code(prescale_ratio_field),
      .tick(prescaler_tick)
   );

   // A tick toggles the output level so that a sampler can see it.
   always @(posedge core_clk)
   begin
      if (any_reset)
         prescaler_output_reg <= 1'b0;
      else if (prescaler_tick)
         prescaler_output_reg <= !prescaler_output_reg;
   end

   // Sampling adds the pin-to-count delay of five to seven clocks.
   phase_edge_sampler u_sampler
   (
      .core_clk(core_clk),
      .rst(any_reset),
      .sample_now(sample_now),
      .level_in(prescaler_output_reg),
      .step(count_step)
   );

   // A written half sits out one instruction cycle; the other half runs on.
   always @(posedge core_clk)
   begin
      if (any_reset)
      begin
         hold_low_reg <= 3'h0;
         hold_high_reg <= 3'h0;
      end
      else
      begin
         if (wr_low)
            hold_low_reg <= `HOLD_CLOCKS;
         else if (hold_low_reg != 3'h0)
            hold_low_reg <= hold_low_reg - 3'h1;
         if (wr_high)
            hold_high_reg <= `HOLD_CLOCKS;
         else if (hold_high_reg != 3'h0)
            hold_high_reg <= hold_high_reg - 3'h1;
      end
   end

   assign low_runs = count_step && (hold_low_reg == 3'h0) && !wr_low;
   assign low_carry = low_runs && (count_low_reg == 8'hff);
   // A carry into a held high half is lost, as the half does not count.
   assign high_runs = low_carry && (hold_high_reg == 3'h0) && !wr_high;
   assign overflow_event = high_runs && (count_high_reg == 8'hff);

   // Counter halves: cleared only at power-on, kept over other resets.
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         count_low_reg <= `COUNT_POWER_ON;
         count_high_reg <= `COUNT_POWER_ON;
      end
      else
      begin
         if (wr_low)
            count_low_reg <= reg_wdata;
         else if (low_runs)
            count_low_reg <= count_low_reg + 8'h01;
         if (wr_high)
            count_high_reg <= reg_wdata;
         else if (high_runs)
            count_high_reg <= count_high_reg + 8'h01;
      end
   end

   // Control register; bit zero is not implemented and reads zero.
   always @(posedge core_clk)
   begin
      if (any_reset)
         control_reg <= `CTL_RESET;
      else if (reg_write && (reg_addr == `OFS_TIMER_CONTROL))
         control_reg <= reg_wdata & `CTL_WRITE_MASK;
   end

   // Global interrupt disable; software sets it around paired accesses.
   always @(posedge core_clk)
   begin
      if (any_reset)
         irq_disable_reg <= `CPU_IRQ_DISABLE_RESET;
      else if (reg_write && (reg_addr == `OFS_CPU_STATUS))
         irq_disable_reg <= reg_wdata[`CPU_IRQ_DISABLE_BIT];
   end

   // Flag clears by writing a one or by vectoring; a new overflow wins.
   assign overflow_clear = irq_vector_ack || (wr_irq && reg_wdata[`IRQ_OVERFLOW_FLAG_BIT]);

   always @(posedge core_clk)
   begin
      if (any_reset)
      begin
         overflow_flag_reg <= `IRQ_FLAG_RESET;
         overflow_enable_reg <= `IRQ_ENABLE_RESET;
      end
      else
      begin
         if (overflow_event)
            overflow_flag_reg <= 1'b1;
         else if (overflow_clear)
            overflow_flag_reg <= 1'b0;
         if (wr_irq)
            overflow_enable_reg <= reg_wdata[`IRQ_OVERFLOW_ENABLE_BIT];
      end
   end

   // Level interrupt, gated by the enable bit and the global disable.
   always @(posedge core_clk)
   begin
      if (any_reset)
         overflow_irq <= 1'b0;
      else
         overflow_irq <= overflow_flag_reg && overflow_enable_reg && !irq_disable_reg;
   end

   // Read data stand in the cycle after the strobe only; unmapped reads give zero.
   always @(posedge core_clk)
   begin
      if (any_reset)
         reg_rdata <= 8'h00;
      else if (reg_read)
      begin
         case (reg_addr)
            `OFS_TIMER_CONTROL:
               reg_rdata <= control_reg;
            `OFS_CPU_STATUS:
               reg_rdata <= {3'h0, irq_disable_reg, 4'h0};
            `OFS_IRQ_STATUS_ENABLE:
               reg_rdata <= {2'h0, overflow_flag_reg, 3'h0, overflow_enable_reg, 1'b0};
            `OFS_COUNT_LOW:
               reg_rdata <= count_low_reg;
            `OFS_COUNT_HIGH:
               reg_rdata <= count_high_reg;
            default:
               reg_rdata <= 8'h00;
         endcase
      end
      else
         reg_rdata <= 8'h00;
   end
endmodule // event_timer
`default_nettype wire

/* event_timer_regs.vh */
// Purpose: Register map, field positions, reset values and timing counts of the event timer.
// Assumes: An 8-bit register port with byte offsets as listed below.
// Notes: Definitions only; include by bare name.
`ifndef EVENT_TIMER_REGS_VH
`define EVENT_TIMER_REGS_VH

// Register offsets.
`define OFS_TIMER_CONTROL 8'h05
`define OFS_CPU_STATUS 8'h06
`define OFS_IRQ_STATUS_ENABLE 8'h07
`define OFS_COUNT_LOW 8'h0b
`define OFS_COUNT_HIGH 8'h0c

// Fields of timer_control.
`define CTL_PIN_IRQ_EDGE_BIT 7
`define CTL_PIN_EDGE_SELECT_BIT 6
`define CTL_CLOCK_SOURCE_BIT 5
`define CTL_RATIO_MSB 4
`define CTL_RATIO_LSB 1
`define CTL_WRITE_MASK 8'hfe
`define CTL_RESET 8'h00

// Fields of cpu_status; only the global disable bit lives here.
`define CPU_IRQ_DISABLE_BIT 4
`define CPU_IRQ_DISABLE_RESET 1'b1

// Fields of interrupt_status_enable.
`define IRQ_OVERFLOW_FLAG_BIT 5
`define IRQ_OVERFLOW_ENABLE_BIT 1
`define IRQ_FLAG_RESET 1'b0
`define IRQ_ENABLE_RESET 1'b0

// Counter value after power-on; the value is arbitrary.
`define COUNT_POWER_ON 8'h00

// Timing: oscillator period and instruction cycle length.
`define OSC_PERIOD_NS 25
`define OSC_PER_INSTR 4
`define PHASE_LAST 2'h3
`define SAMPLE_PHASE_A 2'h0
`define SAMPLE_PHASE_B 2'h2
// A write holds its half for one whole instruction cycle.
`define HOLD_CLOCKS 3'h4

// Prescale codes with the top bit set all mean 1:256.
`define RATIO_MAX_TERMINAL 8'hff

`endif

/* ratio_prescaler.v */
// Purpose: Eight-bit prescaler that turns source events into counter ticks.
// Assumes: Events are one-cycle pulses on core_clk.
// Notes: The ratio may change at any time; the residual count is kept.
`timescale 1ns/1ps
`default_nettype none
`include "event_timer_regs.vh"
module ratio_prescaler
(
   input wire core_clk,
   input wire rst,
   input wire source_event,
   input wire clear_count,
   input wire [3:0] ratio_code,
   output reg tick
);
   reg [7:0] count_reg;
   reg [7:0] terminal;

   // Terminal count: 2^code - 1, or 255 for any code with the top bit set.
   always @*
   begin
      if (ratio_code[3])
         terminal = `RATIO_MAX_TERMINAL;
      else
         terminal = (8'h01 << ratio_code[2:0]) - 8'h01;
   end

   // Count events and restart after each tick; a clear beats an event.
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         count_reg <= 8'h00;
         tick <= 1'b0;
      end
      else if (clear_count)
      begin
         count_reg <= 8'h00;
         tick <= 1'b0;
      end
      else if (source_event && (count_reg >= terminal))
      begin
         // A ratio lowered below the residue wraps at once, not after 256 events.
         count_reg <= 8'h00;
         tick <= 1'b1;
      end
      else
      begin
         count_reg <= count_reg + {7'h00, source_event};
         tick <= 1'b0;
      end
   end
endmodule // ratio_prescaler
`default_nettype wire

/* phase_edge_sampler.v */
// Purpose: Samples the prescaler output level twice per instruction cycle.
// Assumes: level_in comes from a flip-flop on core_clk.
// Notes: Any change between two samples yields one step pulse.
`timescale 1ns/1ps
`default_nettype none
module phase_edge_sampler
(
   input wire core_clk,
   input wire rst,
   input wire sample_now,
   input wire level_in,
   output reg step
);
   reg sampled_reg;

   // Compare each sample with the previous one; both edges count.
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         sampled_reg <= 1'b0;
         step <= 1'b0;
      end
      else
      begin
         if (sample_now)
            sampled_reg <= level_in;
         step <= sample_now && (level_in != sampled_reg);
      end
   end
endmodule // phase_edge_sampler
`default_nettype wire

/* event_timer_chk.sv */
// Purpose: Port assertions for the event timer.
// Assumes: One clock domain; sees top ports only.
// Notes: Bound from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module event_timer_chk
(
   input wire core_clk,
   input wire rst,
   input wire external_reset_pin_n,
   input wire watchdog_timeout,
   input wire irq_vector_ack,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   input wire [7:0] reg_rdata,
   input wire overflow_irq
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   // Read data must stay low outside the slot after a strobe, so stale data never leak.
   AST_RDATA_IDLE:
      assert property (!$past(reg_read) |-> reg_rdata == 8'h00) else $error("stray rdata");
   AST_UNMAPPED:
      assert property (reg_read && !(reg_addr inside {8'h05, 8'h06, 8'h07, 8'h0b, 8'h0c})
         |=> reg_rdata == 8'h00) else $error("unmapped read");
   AST_CTL_READBACK:
      assert property (reg_write && reg_addr == 8'h05 ##1 !reg_write ##1 reg_read &&
         reg_addr == 8'h05 |=> reg_rdata == ($past(reg_wdata, 3) & 8'hfe))
         else $error("control readback");
   AST_IRQ_AFTER_RST:
      assert property ($past(rst) |-> !overflow_irq) else $error("irq after reset");
   AST_IRQ_ACK:
      assert property (irq_vector_ack |=> ##1 !overflow_irq) else $error("irq after ack");
   AST_IRQ_MASK:
      assert property (reg_write && reg_addr == 8'h07 && !reg_wdata[1] |=> ##1 !overflow_irq)
         else $error("irq while masked");
   AST_PIN_RST:
      assert property ((!external_reset_pin_n && !reg_write)[*3] ##1
         (external_reset_pin_n && !reg_write)[*3] ##1 (reg_read && reg_addr == 8'h05)
         |=> reg_rdata == 8'h00) else $error("control after pin reset");
   AST_WDOG_RST:
      assert property (watchdog_timeout && !reg_write ##1 !reg_write ##1
         (reg_read && reg_addr == 8'h05) |=> reg_rdata == 8'h00)
         else $error("control after watchdog");
   // Main scenarios reached.
   cover property ($rose(overflow_irq));
   cover property (irq_vector_ack);
   cover property (watchdog_timeout);
endmodule // event_timer_chk
`default_nettype wire

/* ext_clock_source.sv */
// Purpose: External clock source on the counter clock pin.
// Assumes: Edges land 9 ns after a core edge.
// Notes: The pin stands still between bursts.
`timescale 1ns/1ps
`default_nettype none
module ext_clock_source
(
   input wire core_clk,
   output logic pin_level
);
   // Quiet low level until asked.
   initial pin_level = 1'b0;
   // One level change off the core edge.
   task automatic drive(input logic v);
      @(posedge core_clk);
      #9 pin_level = v;
   endtask
   // Each level held six clocks, wide enough for the twice-per-cycle sampling.
   task automatic burst(input int n);
      repeat (2 * n)
      begin
         drive(~pin_level);
         repeat (5) @(posedge core_clk);
      end
   endtask
endmodule // ext_clock_source
`default_nettype wire

/* event_timer_test.sv */
// Purpose: Self-checking bench for the event timer.
// Assumes: Register header and design compiled first.
// Notes: Counts are ranges where sync delay blurs them.
`timescale 1ns/1ps
`default_nettype none
`include "event_timer_regs.vh"
module event_timer_test;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic external_reset_pin_n = 1'b1;
   logic watchdog_timeout = 1'b0;
   logic irq_vector_ack = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   wire [7:0] reg_rdata;
   wire overflow_irq;
   wire pin;
   logic [7:0] d;
   logic [3:0] code;
   integer seed = 32'h641ec10b;
   int error_cnt = 0;
   int n_checks = 0;
   int n;
   // Oscillator.
   always #12.5 core_clk = ~core_clk;
   event_timer u_dut (.core_clk(core_clk), .rst(rst),
      .external_reset_pin_n(external_reset_pin_n), .watchdog_timeout(watchdog_timeout),
      .counter_clock_pin(pin), .irq_vector_ack(irq_vector_ack), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .overflow_irq(overflow_irq));
   ext_clock_source u_src (.core_clk(core_clk), .pin_level(pin));
   // Prescale ratio of a code.
   function automatic int ratio(input logic [3:0] c);
      return c[3] ? 256 : (1 << c[2:0]);
   endfunction
   // Compares.
   task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic chk_rng(input string w, input logic [7:0] lo, input logic [7:0] hi);
      n_checks++;
      if ((d >= lo && d <= hi) !== 1'b1)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h..%h seen %h", w, lo, hi, d);
      end
   endtask
   // Bus cycles: strobes last one cycle; read data stand in the next.
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string w);
      rd(a);
      chk(w, e, d);
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Hang guard, about four times the expected run.
   initial
   begin
      repeat (40000) @(posedge core_clk);
      error_cnt++;
      final_report();
   end
   // Main sequence.
   initial
   begin
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      rdchk(`OFS_TIMER_CONTROL, 8'h00, "ctl rst");
      rdchk(`OFS_CPU_STATUS, 8'h10, "cpu rst");
      rdchk(`OFS_IRQ_STATUS_ENABLE, 8'h00, "irq rst");
      rdchk(8'h20, 8'h00, "unmapped");
      repeat (3)
      begin
         n = $random(seed);
         wr(`OFS_TIMER_CONTROL, n[7:0]);
         rdchk(`OFS_TIMER_CONTROL, n[7:0] & 8'hfe, "ctl rb");
      end
      // Every ratio; the count write clears the residue so three spans give about 3.
      for (int c = 0; c < 10; c++)
      begin
         n = $random(seed);
         code = (c < 9) ? c[3:0] : 4'h9 + {1'b0, n[2:0] % 3'd7};
         wr(`OFS_COUNT_LOW, 8'h00);
         wr(`OFS_TIMER_CONTROL, {3'b001, code, 1'b0});
         wr(`OFS_COUNT_LOW, 8'h00);
         wr(`OFS_COUNT_HIGH, 8'h00);
         repeat (12 * ratio(code)) @(posedge core_clk);
         rd(`OFS_COUNT_LOW);
         chk_rng("ticks", 8'h02, 8'h04);
      end
      // Pin clock: delay window of one rising edge, then falling edges only.
      wr(`OFS_TIMER_CONTROL, 8'h40);
      wr(`OFS_COUNT_LOW, 8'h00);
      u_src.drive(1'b1);
      rdchk(`OFS_COUNT_LOW, 8'h00, "pin early");
      repeat (5) @(posedge core_clk);
      rdchk(`OFS_COUNT_LOW, 8'h01, "pin late");
      u_src.drive(1'b0);
      repeat (9) @(posedge core_clk);
      rdchk(`OFS_COUNT_LOW, 8'h01, "no fall");
      wr(`OFS_TIMER_CONTROL, 8'h00);
      repeat (10) @(posedge core_clk);
      wr(`OFS_COUNT_LOW, 8'h00);
      u_src.burst(5);
      repeat (9) @(posedge core_clk);
      rdchk(`OFS_COUNT_LOW, 8'h05, "falls");
      // Wrap with the interrupt enabled, masked, re-enabled and acknowledged.
      wr(`OFS_TIMER_CONTROL, 8'h20);
      wr(`OFS_IRQ_STATUS_ENABLE, 8'h02);
      wr(`OFS_CPU_STATUS, 8'h00);
      wr(`OFS_COUNT_LOW, 8'hfc);
      rdchk(`OFS_COUNT_LOW, 8'hfc, "low held");
      wr(`OFS_COUNT_HIGH, 8'hff);
      rdchk(`OFS_COUNT_HIGH, 8'hff, "high held");
      repeat (20) @(posedge core_clk);
      rdchk(`OFS_IRQ_STATUS_ENABLE, 8'h22, "flag");
      rdchk(`OFS_COUNT_HIGH, 8'h00, "wrap");
      chk("irq on", 8'h01, {7'h00, overflow_irq});
      wr(`OFS_IRQ_STATUS_ENABLE, 8'h00);
      rdchk(`OFS_IRQ_STATUS_ENABLE, 8'h20, "masked");
      chk("irq masked", 8'h00, {7'h00, overflow_irq});
      wr(`OFS_IRQ_STATUS_ENABLE, 8'h02);
      @(posedge core_clk);
      irq_vector_ack <= 1'b1;
      @(posedge core_clk);
      irq_vector_ack <= 1'b0;
      rdchk(`OFS_IRQ_STATUS_ENABLE, 8'h02, "acked");
      // Second wrap under the global disable, cleared by writing one.
      wr(`OFS_COUNT_LOW, 8'hfc);
      wr(`OFS_COUNT_HIGH, 8'hff);
      wr(`OFS_CPU_STATUS, 8'h10);
      repeat (24) @(posedge core_clk);
      chk("irq gated", 8'h00, {7'h00, overflow_irq});
      rdchk(`OFS_IRQ_STATUS_ENABLE, 8'h22, "flag gated");
      wr(`OFS_IRQ_STATUS_ENABLE, 8'h22);
      rdchk(`OFS_IRQ_STATUS_ENABLE, 8'h02, "w1c");
      // Soft resets keep a random count; the pin source keeps it still.
      for (int i = 0; i < 2; i++)
      begin
         n = $random(seed);
         wr(`OFS_TIMER_CONTROL, 8'h1e);
         repeat (8) @(posedge core_clk);
         wr(`OFS_COUNT_LOW, n[7:0]);
         wr(`OFS_COUNT_HIGH, n[15:8]);
         if (i == 0)
         begin
            watchdog_timeout <= 1'b1;
            @(posedge core_clk);
            watchdog_timeout <= 1'b0;
         end
         else
         begin
            external_reset_pin_n <= 1'b0;
            repeat (4) @(posedge core_clk);
            external_reset_pin_n <= 1'b1;
            repeat (2) @(posedge core_clk);
         end
         rdchk(`OFS_TIMER_CONTROL, 8'h00, "ctl soft");
         rdchk(`OFS_COUNT_LOW, n[7:0], "low kept");
         rdchk(`OFS_COUNT_HIGH, n[15:8], "high kept");
      end
      final_report();
   end
endmodule // event_timer_test
bind event_timer event_timer_chk u_chk (.core_clk(core_clk), .rst(rst),
   .external_reset_pin_n(external_reset_pin_n), .watchdog_timeout(watchdog_timeout),
   .irq_vector_ack(irq_vector_ack), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .overflow_irq(overflow_irq));
`default_nettype wire
